// file: scb_bus_model.sv
`timescale 1ns/1ps
// ************************************************************
// fetch unit and memory behind the block
// ************************************************************
module scb_bus_model
  import scb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [1:0] lag,
  input wire logic fetchReq,
  input wire logic [AW-1:0] fetchAddr,
  output logic fetchValid,
  output logic [15:0] fetchWord,
  input wire logic memRd,
  input wire logic memWr,
  input wire logic memWord,
  input wire logic [AW-1:0] memAddr,
  input wire logic [15:0] memWdata,
  output logic memDone,
  output logic [15:0] memRdata
);
  logic [15:0] prog [logic [AW-1:0]];
  logic [7:0] mem [logic [AW-1:0]];
  logic [1:0] fWait_r;
  logic [1:0] mWait_r;
  function automatic logic [7:0] peek(input logic [AW-1:0] a);
    return mem.exists(a) ? mem[a] : 8'h00;
  endfunction
  // unwritten code reads as a return, so a trap handler comes straight back
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fetchValid <= 1'b0;
      fetchWord <= 16'h0000;
      fWait_r <= 2'h0;
    end else if (fetchValid) begin
      fetchValid <= 1'b0;
      fetchWord <= ~fetchWord;
    end else if (fetchReq && fWait_r != 2'h0) begin
      fWait_r <= fWait_r - 2'h1;
    end else if (fetchReq) begin
      fetchValid <= 1'b1;
      fetchWord <= prog.exists(fetchAddr) ? prog[fetchAddr] : 16'h5600;
      fWait_r <= lag;
    end
  end
  // a byte read shows the byte in both halves; big-endian words
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      memDone <= 1'b0;
      memRdata <= 16'h0000;
      mWait_r <= 2'h0;
    end else if (memDone) begin
      memDone <= 1'b0;
      memRdata <= ~memRdata;
    end else if ((memRd || memWr) && mWait_r != 2'h0) begin
      mWait_r <= mWait_r - 2'h1;
    end else if (memRd || memWr) begin
      memDone <= 1'b1;
      mWait_r <= lag;
      if (memRd) begin
        memRdata <= {peek(memAddr),
          memWord ? peek(memAddr + PTR_STEP) : peek(memAddr)};
      end else if (memWord) begin
        mem[memAddr] = memWdata[15:8];
        mem[memAddr + PTR_STEP] = memWdata[7:0];
      end else begin
        mem[memAddr] = memWdata[7:0];
      end
    end
  end
endmodule // scb_bus_model

// file: scb_dec_if.sv
`timescale 1ns/1ps
interface scb_dec_if;
  import scb_pkg::*;
  logic [15:0] word;
  logic [7:0] opcode;
  logic [3:0] opHi;
  logic [3:0] opLo;
  logic [3:0] cond;
  logic [2:0] regA;
  logic [3:0] regD;
  logic [1:0] trapVec;
  logic [2:0] bitNum;
  logic [2:0] bitKind;
  logic [1:0] extLen;
  logic isBranch;
  modport dec (input word, output opcode, opHi, opLo, cond, regA, regD,
    trapVec, bitNum, bitKind, extLen, isBranch);
  modport core (output word, input opcode, opHi, opLo, cond, regA, regD,
    trapVec, bitNum, bitKind, extLen, isBranch);
endinterface

// file: scb_field_dec.sv
`timescale 1ns/1ps
module scb_field_dec
  import scb_pkg::*;
(
  scb_dec_if.dec d
);
  // ************************************************************
  // field slicing of the first word, plus the extension-length decode of its opcode
  // ************************************************************
  assign d.opcode = d.word[15:8];
  assign d.opHi = d.word[OPF_HI:OPF_LO];
  assign d.opLo = d.word[OP2_HI:OP2_LO];
  assign d.cond = d.word[COND_HI:COND_LO];
  assign d.regA = d.word[REGA_HI:REGA_LO];
  assign d.regD = d.word[REGD_HI:REGD_LO];
  assign d.trapVec = d.word[TRAPV_HI:TRAPV_LO];
  assign d.bitNum = d.word[BITN_HI:BITN_LO];
  assign d.bitKind = d.word[BITKIND_HI:BITKIND_LO];
  assign d.isBranch = (d.word[OPF_HI:OPF_LO] == OPHI_BRANCH);

  always_comb begin
    unique case (d.word[15:8])
      OP_FLAGLDM, OP_FLAGSTM: d.extLen = EXT_32;
      OP_FLAGOR, OP_FLAGXOR, OP_FLAGAND, OP_FLAGLD: d.extLen = EXT_NONE;
      default: d.extLen = EXT_NONE;
    endcase
  end
endmodule // scb_field_dec

// file: scb_pkg.sv
package scb_pkg;
  // ************************************************************
  // instruction opcode space (first byte of the first word)
  // ************************************************************
  localparam logic [7:0] OP_IDLE = 8'h00;
  localparam logic [7:0] OP_SLEEP = 8'h01;
  localparam logic [7:0] OP_FLAGLD = 8'h02;
  localparam logic [7:0] OP_FLAGST = 8'h03;
  localparam logic [7:0] OP_FLAGOR = 8'h04;
  localparam logic [7:0] OP_FLAGXOR = 8'h05;
  localparam logic [7:0] OP_FLAGAND = 8'h06;
  localparam logic [7:0] OP_FLAGLDM = 8'h07;
  localparam logic [7:0] OP_FLAGSTM = 8'h08;
  localparam logic [7:0] OP_RETURN = 8'h56;
  localparam logic [7:0] OP_TRAP = 8'h57;
  localparam logic [7:0] OP_BLKB = 8'h7b;
  localparam logic [7:0] OP_BLKW = 8'h7c;
  localparam logic [7:0] OP_BITRMW = 8'h7d;
  localparam logic [3:0] OPHI_BRANCH = 4'h4;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int OPF_HI = 15;
  localparam int OPF_LO = 12;
  localparam int OP2_HI = 11;
  localparam int OP2_LO = 8;
  localparam int COND_HI = 11;
  localparam int COND_LO = 8;
  localparam int REGA_HI = 6;
  localparam int REGA_LO = 4;
  localparam int REGD_HI = 3;
  localparam int REGD_LO = 0;
  localparam int TRAPV_HI = 5;
  localparam int TRAPV_LO = 4;
  localparam int BITN_HI = 6;
  localparam int BITN_LO = 4;
  localparam int BITKIND_HI = 2;
  localparam int BITKIND_LO = 0;

  // ************************************************************
  // widths, steps and reset values
  // ************************************************************
  localparam int AW = 24;
  localparam logic [7:0] EXT_TOP = 8'h00;
  localparam logic [AW-1:0] PC_STEP = 24'h000002;
  localparam logic [AW-1:0] PTR_STEP = 24'h000001;
  localparam logic [AW-1:0] PC_RESET = 24'h000100;
  localparam logic [AW-1:0] TRAP_VEC_BASE = 24'h000020;
  localparam int TRAP_VEC_SHIFT = 2;
  localparam logic [7:0] FLAG_RESET = 8'h80;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [1:0] EXT_NONE = 2'h0;
  localparam logic [1:0] EXT_8 = 2'h1;
  localparam logic [1:0] EXT_16 = 2'h2;
  localparam logic [1:0] EXT_32 = 2'h3;
  localparam int FLAG_CARRY = 0;

  // single-bit kinds
  localparam logic [2:0] BK_SET = 3'h0;
  localparam logic [2:0] BK_CLR = 3'h1;
  localparam logic [2:0] BK_INV = 3'h2;
  localparam logic [2:0] BK_ST = 3'h3;
  localparam logic [2:0] BK_IST = 3'h4;

  typedef enum logic [9:0] {
    S_FETCH = 10'b0000000001,
    S_EXT = 10'b0000000010,
    S_EXEC = 10'b0000000100,
    S_MRD = 10'b0000001000,
    S_MWR = 10'b0000010000,
    S_BRD = 10'b0000100000,
    S_BWR = 10'b0001000000,
    S_TRAP = 10'b0010000000,
    S_RET = 10'b0100000000,
    S_SLEEP = 10'b1000000000
  } scb_state_t;
endpackage

// file: scb_sysctl.sv
`timescale 1ns/1ps
// Overview of operation
// - trap instruction starts trap exception handling
// - exception return leaves handler and resumes interrupted flow
// - sleep instruction enters power-down state
// - flag load from memory uses a word read
// - flag store to memory uses a word write
// - flag AND immediate: flags become flags AND byte immediate
// - flag OR immediate: flags become flags OR byte immediate
// - flag XOR immediate: flags become flags XOR byte immediate
// - idle instruction only advances program counter by two
// - byte-counted move skips on zero count, else copies until zero
// - word-counted move uses 16-bit count the same way
// - each byte read at source, written at destination, both increment
// - next instruction starts right after the last byte moves
// - instructions fetched and decoded as whole 16-bit words
// - operation field is at least the top four bits
// - register fields are 3 or 4 bits, zero to two of them
// - only a 32-bit extension is fetched, for flag load and flag store to memory
// - 24-bit extension held as 32 bits with zero top byte
// - branch condition taken from the condition field
// - single-bit ops read a byte, change one bit, write back
// - trap carries 2-bit field selecting the vector
module scb_sysctl
  import scb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  // instruction fetch
  output logic fetchReq,
  output logic [AW-1:0] fetchAddr,
  input wire logic fetchValid,
  input wire logic [15:0] fetchWord,
  // memory bus
  output logic memRd,
  output logic memWr,
  output logic memWord,
  output logic [AW-1:0] memAddr,
  output logic [15:0] memWdata,
  input wire logic memDone,
  input wire logic [15:0] memRdata,
  // general registers used by the block move and bit operations; the stack pointer input is not used
  input wire logic [15:0] longCountIn,
  input wire logic [AW-1:0] srcPtrIn,
  input wire logic [AW-1:0] dstPtrIn,
  input wire logic [AW-1:0] bitAddrIn,
  input wire logic [AW-1:0] stackPtrIn,
  output logic [15:0] longCount,
  output logic [AW-1:0] srcPtr,
  output logic [AW-1:0] dstPtr,
  // status
  output logic [7:0] flagByte,
  output logic [AW-1:0] progCount,
  output logic sleeping,
  output logic [AW-1:0] trapVector,
  output logic inTrap,
  output logic blockBusy,
  output logic [31:0] extData,
  output logic [3:0] branchCond,
  output logic [2:0] regSelA,
  output logic [3:0] regSelD,
  input wire logic wakeUp
);
  // ************************************************************
  // state
  // ************************************************************
  scb_state_t state_r, state_nxt;
  logic [15:0] instr_r;
  logic [31:0] ext_r;
  logic extHalf_r;
  logic [1:0] extLen_r;
  logic [7:0] flag_r;
  logic [AW-1:0] pc_r;
  logic [AW-1:0] retPc_r;
  logic [7:0] retFlag_r;
  logic [15:0] cnt_r;
  logic [AW-1:0] src_r;
  logic [AW-1:0] dst_r;
  logic [7:0] byte_r;
  logic [AW-1:0] vec_r;
  logic wide_r;
  logic trap_r;
  logic memBusy_r;

  scb_dec_if dif();
  assign dif.word = (state_r == S_FETCH) ? fetchWord : instr_r;
  scb_field_dec u_dec (
    .d(dif)
  );

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [7:0] bit_modify(input logic [7:0] b,
      input logic [2:0] n, input logic [2:0] kind, input logic c);
    logic [7:0] r;
    r = b;
    unique case (kind)
      BK_SET: r[n] = 1'b1;
      BK_CLR: r[n] = 1'b0;
      BK_INV: r[n] = ~b[n];
      BK_ST: r[n] = c;
      BK_IST: r[n] = ~c;
      default: r = b;
    endcase
    return r;
  endfunction

  function automatic logic [15:0] count_of(input logic wide,
      input logic [15:0] c);
    return wide ? c : {8'h00, c[7:0]};
  endfunction

  logic [15:0] startCnt;
  logic isBlk;
  logic isMemOp;
  logic lastByte;
  assign isBlk = (dif.opcode == OP_BLKB) || (dif.opcode == OP_BLKW);
  assign startCnt = count_of(dif.opcode == OP_BLKW, longCountIn);
  assign isMemOp = (dif.opcode == OP_FLAGLDM) ||
    (dif.opcode == OP_FLAGSTM) || (dif.opcode == OP_BITRMW);
  assign lastByte = (count_of(wide_r, cnt_r) == CNT_ONE);

  // ************************************************************
  // sequencing
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_FETCH: begin
        if (fetchValid) begin
          if (dif.extLen != EXT_NONE) state_nxt = S_EXT;
          else state_nxt = S_EXEC;
        end
      end
      S_EXT: begin
        if (fetchValid && (extLen_r != EXT_32 || extHalf_r))
          state_nxt = S_EXEC;
      end
      S_EXEC: begin
        unique case (dif.opcode)
          OP_TRAP: state_nxt = S_TRAP;
          OP_RETURN: state_nxt = S_RET;
          OP_SLEEP: state_nxt = S_SLEEP;
          OP_FLAGLDM: state_nxt = S_MRD;
          OP_BITRMW: state_nxt = S_MRD;
          OP_FLAGSTM: state_nxt = S_MWR;
          OP_BLKB, OP_BLKW: begin
            // zero count falls straight through
            if (startCnt == CNT_ZERO) state_nxt = S_FETCH;
            else state_nxt = S_BRD;
          end
          default: state_nxt = S_FETCH;
        endcase
      end
      S_MRD: begin
        if (memDone) begin
          if (dif.opcode == OP_BITRMW) state_nxt = S_MWR;
          else state_nxt = S_FETCH;
        end
      end
      S_MWR: if (memDone) state_nxt = S_FETCH;
      S_BRD: if (memDone) state_nxt = S_BWR;
      S_BWR: begin
        if (memDone) begin
          if (lastByte) state_nxt = S_FETCH;
          else state_nxt = S_BRD;
        end
      end
      S_TRAP: state_nxt = S_FETCH;
      S_RET: state_nxt = S_FETCH;
      S_SLEEP: if (wakeUp) state_nxt = S_FETCH;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) state_r <= S_FETCH;
    else if (clkEn) state_r <= state_nxt;
  end

  // ************************************************************
  // instruction capture and extension words
  // ************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      instr_r <= 16'h0000;
      extLen_r <= EXT_NONE;
    end else if (clkEn && state_r == S_FETCH && fetchValid) begin
      instr_r <= fetchWord;
      extLen_r <= dif.extLen;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_r <= 32'h00000000;
      extHalf_r <= 1'b0;
    end else if (clkEn) begin
      if (state_r == S_FETCH) begin
        extHalf_r <= 1'b0;
      end else if (state_r == S_EXT && fetchValid) begin
        unique case (extLen_r)
          EXT_8: ext_r <= {24'h000000, fetchWord[7:0]};
          EXT_16: ext_r <= {16'h0000, fetchWord};
          default: begin
            if (!extHalf_r) ext_r[31:16] <= fetchWord;
            else ext_r[15:0] <= fetchWord;
            extHalf_r <= 1'b1;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // program counter and trap/return
  // ************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_r <= PC_RESET;
    end else if (clkEn) begin
      if ((state_r == S_FETCH || state_r == S_EXT) && fetchValid)
        pc_r <= pc_r + PC_STEP;
      else if (state_r == S_TRAP)
        pc_r <= vec_r;
      else if (state_r == S_RET)
        pc_r <= retPc_r;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      vec_r <= TRAP_VEC_BASE;
      retPc_r <= PC_RESET;
      retFlag_r <= FLAG_RESET;
      trap_r <= 1'b0;
    end else if (clkEn) begin
      if (state_r == S_EXEC && dif.opcode == OP_TRAP) begin
        vec_r <= TRAP_VEC_BASE + (AW'(dif.trapVec) << TRAP_VEC_SHIFT);
        retPc_r <= pc_r;
        retFlag_r <= flag_r;
        trap_r <= 1'b1;
      end else if (state_r == S_RET) begin
        trap_r <= 1'b0;
      end
    end
  end

  // ************************************************************
  // flag byte
  // ************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_r <= FLAG_RESET;
    end else if (clkEn) begin
      if (state_r == S_EXEC) begin
        unique case (dif.opcode)
          OP_FLAGAND: flag_r <= flag_r & instr_r[7:0];
          OP_FLAGOR: flag_r <= flag_r | instr_r[7:0];
          OP_FLAGXOR: flag_r <= flag_r ^ instr_r[7:0];
          OP_FLAGLD: flag_r <= instr_r[7:0];
          default: flag_r <= flag_r;
        endcase
      end else if (state_r == S_MRD && memDone && dif.opcode == OP_FLAGLDM) begin
        // word read, flags are the even (upper) byte
        flag_r <= memRdata[15:8];
      end else if (state_r == S_RET) begin
        flag_r <= retFlag_r;
      end
    end
  end

  // ************************************************************
  // block move counters and pointers
  // ************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= CNT_ZERO;
      src_r <= '0;
      dst_r <= '0;
      wide_r <= 1'b0;
    end else if (clkEn) begin
      if (state_r == S_EXEC && isBlk) begin
        cnt_r <= longCountIn;
        src_r <= srcPtrIn;
        dst_r <= dstPtrIn;
        wide_r <= (dif.opcode == OP_BLKW);
      end else if (state_r == S_BWR && memDone) begin
        cnt_r <= cnt_r - CNT_ONE;
        src_r <= src_r + PTR_STEP;
        dst_r <= dst_r + PTR_STEP;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) byte_r <= 8'h00;
    else if (clkEn && memDone) begin
      if (state_r == S_BRD) byte_r <= memRdata[7:0];
      else if (state_r == S_MRD)
        byte_r <= bit_modify(memRdata[7:0], dif.bitNum, dif.bitKind,
          flag_r[FLAG_CARRY]);
    end
  end

  // ************************************************************
  // bus drive: move bytes, flag load/store words and single-bit op bytes
  // ************************************************************
  always_comb begin
    memRd = 1'b0;
    memWr = 1'b0;
    memWord = 1'b0;
    memAddr = '0;
    memWdata = 16'h0000;
    unique case (state_r)
      S_BRD: begin
        memRd = 1'b1;
        memAddr = src_r;
      end
      S_BWR: begin
        memWr = 1'b1;
        memAddr = dst_r;
        memWdata = {8'h00, byte_r};
      end
      S_MRD: begin
        memRd = 1'b1;
        memWord = (dif.opcode == OP_FLAGLDM);
        memAddr = (dif.opcode == OP_FLAGLDM) ? ext_r[AW-1:0] : bitAddrIn;
      end
      S_MWR: begin
        memWr = 1'b1;
        memWord = (dif.opcode == OP_FLAGSTM);
        memAddr = (dif.opcode == OP_FLAGSTM) ? ext_r[AW-1:0] : bitAddrIn;
        memWdata = (dif.opcode == OP_FLAGSTM) ?
          {flag_r, 8'h00} : {8'h00, byte_r};
      end
      default: memAddr = '0;
    endcase
  end

  assign fetchReq = (state_r == S_FETCH) || (state_r == S_EXT);
  assign fetchAddr = pc_r;
  assign flagByte = flag_r;
  assign progCount = pc_r;
  assign sleeping = (state_r == S_SLEEP);
  assign trapVector = vec_r;
  assign inTrap = trap_r;
  assign blockBusy = (state_r == S_BRD) || (state_r == S_BWR);
  assign longCount = cnt_r;
  assign srcPtr = src_r;
  assign dstPtr = dst_r;
  // 24-bit values arrive with zero top byte
  assign extData = (extLen_r == EXT_32) ?
    {EXT_TOP, ext_r[AW-1:0]} : ext_r;
  assign branchCond = dif.isBranch ? dif.cond : 4'h0;
  assign regSelA = dif.regA;
  assign regSelD = dif.regD;
  logic unusedStack;
  assign unusedStack = |stackPtrIn | memBusy_r;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) memBusy_r <= 1'b0;
    else if (clkEn) memBusy_r <= memRd | memWr;
  end
endmodule // scb_sysctl

// file: scb_sysctl_bench.sv
`timescale 1ns/1ps
// ************************************************************
// self-checking bench
// ************************************************************
module scb_sysctl_bench
  import scb_pkg::*;
;
  logic sys_clk, reset_n, wakeUp, inTrapQ;
  logic [1:0] lag;
  logic [15:0] longCountIn;
  logic [AW-1:0] srcPtrIn, dstPtrIn, bitAddrIn, pcB;
  logic fetchReq, fetchValid, memRd, memWr, memWord, memDone;
  logic sleeping, inTrap, blockBusy;
  logic [AW-1:0] fetchAddr, memAddr, trapVector;
  logic [15:0] fetchWord, memWdata, memRdata;
  logic [31:0] extData;
  logic [7:0] flagByte, fl;
  logic [40:0] wq[$];
  logic [24:0] rq[$];
  logic [31:0] fq[$];
  logic [23:0] tq[$];
  logic [15:0] cntT [logic [23:0]];
  logic [23:0] srcT [logic [23:0]], dstT [logic [23:0]], bitT [logic [23:0]];
  logic [7:0] flagOps [4] = '{OP_FLAGOR, OP_FLAGXOR, OP_FLAGAND, OP_FLAGLD};
  integer seed = 87180, num_errors = 0, check_count = 0;
  scb_sysctl dut (.sys_clk, .reset_n, .clkEn(1'b1), .fetchReq, .fetchAddr,
    .fetchValid, .fetchWord, .memRd, .memWr, .memWord, .memAddr, .memWdata,
    .memDone, .memRdata, .longCountIn, .srcPtrIn, .dstPtrIn, .bitAddrIn,
    .stackPtrIn(24'h000000), .longCount(), .srcPtr(), .dstPtr(), .flagByte,
    .progCount(), .sleeping, .trapVector, .inTrap, .blockBusy, .extData,
    .branchCond(), .regSelA(), .regSelD(), .wakeUp);
  scb_bus_model mdl (.sys_clk, .reset_n, .lag, .fetchReq, .fetchAddr,
    .fetchValid, .fetchWord, .memRd, .memWr, .memWord, .memAddr, .memWdata,
    .memDone, .memRdata);
  task conclude;
    if (num_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task cmp(input logic [40:0] got, input logic [40:0] exp, input string s);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task put(input logic [15:0] w);
    mdl.prog[pcB] = w;
    fq.push_back({pcB, fl});
    pcB = pcB + PC_STEP;
  endtask
  task ext(input logic [23:0] a);
    put({EXT_TOP, a[23:16]});
    put(a[15:0]);
  endtask
  task blk(input logic [7:0] op, input logic [15:0] c, input int n);
    logic [7:0] v;
    cntT[pcB] = c;
    srcT[pcB] = {8'h10, 16'($random(seed))};
    dstT[pcB] = {8'h20, 16'($random(seed))};
    for (int i = 0; i < n; i++) begin
      v = 8'($random(seed));
      mdl.mem[srcT[pcB] + 24'(i)] = v;
      rq.push_back({1'b0, srcT[pcB] + 24'(i)});
      wq.push_back({1'b0, dstT[pcB] + 24'(i), 8'h00, v});
    end
    put({op, 8'h00});
  endtask
  task build;
    logic [7:0] v, m, r;
    logic [2:0] b;
    logic [23:0] a;
    pcB = PC_RESET;
    fl = FLAG_RESET;
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      put({flagOps[i % 4], v});
      case (i % 4)
        0: fl = fl | v;
        1: fl = fl ^ v;
        2: fl = fl & v;
        default: fl = v;
      endcase
    end
    put({OP_IDLE, 8'h00});
    a = 24'h003000;
    mdl.mem[a] = 8'($random(seed));
    mdl.mem[a + PTR_STEP] = 8'($random(seed));
    put({OP_FLAGLDM, 8'h00});
    ext(a);
    rq.push_back({1'b1, a});
    fl = mdl.mem[a];
    put({OP_FLAGSTM, 8'h00});
    ext(24'h005000);
    wq.push_back({1'b1, 24'h005000, fl, 8'h00});
    for (int k = 0; k < 5; k++) begin
      a = 24'h004000 + 24'(k);
      v = 8'($random(seed));
      b = 3'($random(seed));
      m = 8'h01 << b;
      mdl.mem[a] = v;
      bitT[pcB] = a;
      case (k)
        0: r = v | m;
        1: r = v & ~m;
        2: r = v ^ m;
        3: r = fl[FLAG_CARRY] ? v | m : v & ~m;
        default: r = fl[FLAG_CARRY] ? v & ~m : v | m;
      endcase
      rq.push_back({1'b0, a});
      wq.push_back({1'b0, a, 8'h00, r});
      put({OP_BITRMW, 1'b0, b, 1'b0, 3'(k)});
    end
    blk(OP_BLKB, 16'h5503, 3);
    blk(OP_BLKB, 16'h0300, 0);
    blk(OP_BLKW, 16'h0000, 0);
    blk(OP_BLKW, 16'h0102, 258);
    put({OP_SLEEP, 8'h00});
    for (int n = 0; n < 4; n++) begin
      tq.push_back(TRAP_VEC_BASE + 24'(n * 4));
      put({OP_TRAP, 2'b00, 2'(n), 4'h0});
    end
    put({OP_IDLE, 8'h00});
  endtask
  // ************************************************************
  // stimulus
  // ************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    inTrapQ = 1'b0;
    reset_n = 1'b0;
    {lag, longCountIn, srcPtrIn, dstPtrIn, bitAddrIn} = '0;
    build();
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    while (fq.size() || wq.size() || rq.size() || tq.size())
      @(posedge sys_clk);
    repeat (10) @(posedge sys_clk);
    conclude();
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    num_errors++;
    conclude();
  end
  initial begin
    wakeUp = 1'b0;
    forever begin
      @(posedge sys_clk);
      if (sleeping === 1'b1) begin
        repeat (6) @(posedge sys_clk);
        cmp(41'(sleeping), 41'h1, "sleep");
        wakeUp <= 1'b1;
        @(posedge sys_clk);
        wakeUp <= 1'b0;
      end
    end
  end
  always @(posedge sys_clk) begin
    lag <= 2'($random(seed));
    if (fetchReq && fetchValid && cntT.exists(fetchAddr)) begin
      longCountIn <= cntT[fetchAddr];
      srcPtrIn <= srcT[fetchAddr];
      dstPtrIn <= dstT[fetchAddr];
    end
    if (fetchReq && fetchValid && bitT.exists(fetchAddr))
      bitAddrIn <= bitT[fetchAddr];
  end
  // ************************************************************
  // result watcher
  // ************************************************************
  always @(posedge sys_clk) begin
    if (reset_n && fetchReq && fetchValid && !inTrap && fq.size() > 0)
      cmp(41'({fetchAddr, flagByte}), 41'(fq.pop_front()), "fetch");
    if (reset_n && memDone && memRd && rq.size() > 0)
      cmp(41'({memWord, memAddr}), 41'(rq.pop_front()), "read");
    if (reset_n && memDone && memWord)
      cmp(41'(extData), 41'(memAddr), "ext");
    if (reset_n && memDone && memWr && !inTrap)
      cmp({memWord, memAddr, memWord ? memWdata : {8'h00, memWdata[7:0]}},
        wq.size() > 0 ? wq.pop_front() : '1, "write");
    if (reset_n && inTrap && !inTrapQ && tq.size() > 0)
      cmp(41'(trapVector), 41'(tq.pop_front()), "vector");
    inTrapQ = inTrap;
  end
endmodule // scb_sysctl_bench

// file: scb_sysctl_properties.sv
`timescale 1ns/1ps
// ************************************************************
// port-level checks
// ************************************************************
module scb_sysctl_properties
  import scb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic fetchReq,
  input wire logic fetchValid,
  input wire logic [15:0] fetchWord,
  input wire logic memRd,
  input wire logic memWr,
  input wire logic memWord,
  input wire logic [AW-1:0] memAddr,
  input wire logic memDone,
  input wire logic [AW-1:0] srcPtr,
  input wire logic [AW-1:0] dstPtr,
  input wire logic [7:0] flagByte,
  input wire logic sleeping,
  input wire logic [AW-1:0] trapVector,
  input wire logic inTrap,
  input wire logic blockBusy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire taken = fetchReq && fetchValid && clkEn;
  wire [7:0] op = fetchWord[15:8];
  wire [7:0] imm = fetchWord[7:0];
  logic [1:0] trapSel_r;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) trapSel_r <= 2'h0;
    else if (taken && op == OP_TRAP) begin
      trapSel_r <= fetchWord[TRAPV_HI:TRAPV_LO];
    end
  end
  sequence s_op(logic [7:0] code);
    taken && op == code;
  endsequence
  property p_flag_or;
    s_op(OP_FLAGOR) |-> ##2 flagByte == ($past(flagByte, 2) | $past(imm, 2));
  endproperty
  a_flag_or: assert property (p_flag_or) else $error("flag or");
  property p_flag_xor;
    s_op(OP_FLAGXOR) |=> ##1 flagByte == ($past(flagByte, 2) ^ $past(imm, 2));
  endproperty
  a_flag_xor: assert property (p_flag_xor) else $error("flag xor");
  property p_flag_and;
    s_op(OP_FLAGAND) |-> ##2 flagByte == ($past(flagByte, 2) & $past(imm, 2));
  endproperty
  a_flag_and: assert property (p_flag_and) else $error("flag and");
  property p_blk_quiet;
    blockBusy |-> !fetchReq && !memWord;
  endproperty
  a_blk_quiet: assert property (p_blk_quiet) else $error("move bus");
  property p_blk_src;
    blockBusy && memRd |-> memAddr == srcPtr;
  endproperty
  a_blk_src: assert property (p_blk_src) else $error("move src");
  property p_blk_dst;
    blockBusy && memWr |-> memAddr == dstPtr;
  endproperty
  a_blk_dst: assert property (p_blk_dst) else $error("move dst");
  property p_rd_hold;
    memRd && !memDone |=> memRd && $stable(memAddr);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read drop");
  property p_sleep_in;
    s_op(OP_SLEEP) |-> ##[1:3] sleeping;
  endproperty
  a_sleep_in: assert property (p_sleep_in) else $error("no sleep");
  property p_sleep_quiet;
    sleeping |-> !fetchReq && !memRd && !memWr;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("sleep bus");
  property p_trap_in;
    s_op(OP_TRAP) |-> ##[1:20] inTrap;
  endproperty
  a_trap_in: assert property (p_trap_in) else $error("no trap");
  property p_trap_vec;
    $rose(inTrap) |->
      trapVector == TRAP_VEC_BASE + {20'h00000, trapSel_r, 2'b00};
  endproperty
  a_trap_vec: assert property (p_trap_vec) else $error("vector");
  property p_ret;
    inTrap && taken && op == OP_RETURN |-> ##[1:20] !inTrap;
  endproperty
  a_ret: assert property (p_ret) else $error("no return");
  c_move: cover property (blockBusy && memWr && memDone);
  c_trap: cover property ($rose(inTrap));
  c_wake: cover property ($fell(sleeping));
endmodule // scb_sysctl_properties

bind scb_sysctl scb_sysctl_properties u_props (.sys_clk, .reset_n, .clkEn,
  .fetchReq, .fetchValid, .fetchWord, .memRd, .memWr, .memWord, .memAddr,
  .memDone, .srcPtr, .dstPtr, .flagByte, .sleeping, .trapVector, .inTrap,
  .blockBusy);
